// ### include/gpb_defines.vh
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH

// register indices; byte address is four times the index
`define GPB_IDX_PIN60       10'h047
`define GPB_IDX_PIN61       10'h048
`define GPB_IDX_PIN62       10'h049
`define GPB_IDX_B8DATA      10'h04a
`define GPB_IDX_IRQSTAT     10'h060
`define GPB_IDX_IRQMASK     10'h061
`define GPB_IDX_B8RSTEN     10'h062
`define GPB_IDX_B8DIR       10'h063
`define GPB_IDX_PINSTAT     10'h064
`define GPB_IDX_B6DATA      10'h065

// reset values
`define GPB_RST_PIN60       8'h01
`define GPB_RST_PIN61       8'h04
`define GPB_RST_PIN62       8'h01
`define GPB_RST_B8DATA      8'hf0
`define GPB_RST_B8DIR       8'h00
`define GPB_RST_ZERO8       8'h00
`define GPB_RST_ZERO3       3'h0

// configuration field positions
`define GPB_BIT_DIR         0
`define GPB_BIT_POL         1
`define GPB_BIT_FN_LO       2
`define GPB_BIT_FN_HI       3
`define GPB_BIT_ODRAIN      7

// function select encodings
`define GPB_FN_GPIO         2'h0
`define GPB_FN_INDICATOR    2'h1
`define GPB_FN_EDGE_IRQ     2'h2

// interrupt status bit positions
`define GPB_EV_EDGE4        0
`define GPB_EV_EDGE5        1
`define GPB_EV_IRQC         2

`endif

// ### rtl/gpb_bank_config.v
// Contract
// RULE1: config bit 0: one input, zero output
// RULE2: config bit 1 inverts pin value
// RULE3: config bit 7: one open-drain, zero push-pull
// RULE4: pin 6.0 function: gpio, indicator one, edge four
// RULE5: pin 6.1 function: gpio, indicator two, edge five
// RULE6: pin 6.2 bit 2 selects request input C
// RULE7: software never writes reserved function code 11
// RULE8: bank 8 data bit n drives pin n
// RULE9: standby reset: bank 8 outputs, data 0xf0
// RULE10: main or bus reset clears enabled bank 8 bits; the code loads enabled bits from reset data 0xf0 instead
// RULE11: alternate function owns pin, gpio path released
`include "gpb_defines.vh"

module gpb_bank_config (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        mainPowerReset,
  input  wire        hostBusReset,
  input  wire        indicatorOutOne,
  input  wire        indicatorOutTwo,
  output reg         irqRequestInputC,
  output reg         irqOut,
  input  wire [2:0]  bank6PinIn,
  output reg  [2:0]  bank6PinOut,
  output reg  [2:0]  bank6PinOe,
  input  wire [7:0]  bank8PinIn,
  output reg  [7:0]  bank8PinOut,
  output reg  [7:0]  bank8PinOe
);

  // true when the byte address equals the word-aligned address of a register index
  function hit;
    input [11:0] addr;
    input [9:0]  idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  // pin level and enable for a driven value under the chosen driver type
  function [1:0] drive;
    input val;
    input openDrain;
    begin
      if (openDrain) begin
        drive = {1'b0, ~val}; // only pulls low, pull-up makes the high
      end else begin
        drive = {val, 1'b1};
      end
    end
  endfunction

  reg  [7:0] pin60Reg;
  reg  [7:0] pin61Reg;
  reg  [7:0] pin62Reg;
  reg  [7:0] b8DataReg;
  reg  [7:0] b8DataNext;
  reg  [7:0] b8DirReg;
  reg  [7:0] b8RstEnReg;
  reg  [2:0] b6DataReg;
  reg  [2:0] irqStatReg;
  reg  [2:0] irqStatNext;
  reg  [2:0] irqMaskReg;
  reg  [2:0] b6Sync1Reg;
  reg  [2:0] b6Sync2Reg;
  reg  [2:0] b6PrevReg;
  reg  [7:0] b8Sync1Reg;
  reg  [7:0] b8Sync2Reg;
  reg  [31:0] rdData;
  reg        mapped;
  reg  [2:0] pinDrv;
  reg  [2:0] pinIsOut;
  reg  [2:0] events;
  reg  [1:0] d0;
  reg  [1:0] d1;
  reg  [1:0] d2;
  reg  [7:0] b8Out;
  reg  [7:0] b8Oe;
  integer    i;

  wire       setup  = psel & ~penable;
  wire       wrDone = psel & penable & pready & pwrite;
  wire [1:0] fn60   = pin60Reg[`GPB_BIT_FN_HI:`GPB_BIT_FN_LO];
  wire [1:0] fn61   = pin61Reg[`GPB_BIT_FN_HI:`GPB_BIT_FN_LO];
  wire       fn62   = pin62Reg[`GPB_BIT_FN_LO];
  wire [2:0] polMask = {pin62Reg[`GPB_BIT_POL], pin61Reg[`GPB_BIT_POL], pin60Reg[`GPB_BIT_POL]};
  // pin value as seen by the data path, after optional inversion
  wire [2:0] b6Seen = b6Sync2Reg ^ polMask; // RULE2
  wire [2:0] b6Prev = b6PrevReg ^ polMask;

  // two-flop synchronisers for all pins; bank 6 adds a third stage holding the previous value for edges
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      b6Sync1Reg <= `GPB_RST_ZERO3;
      b6Sync2Reg <= `GPB_RST_ZERO3;
      b6PrevReg  <= `GPB_RST_ZERO3;
      b8Sync1Reg <= `GPB_RST_ZERO8;
      b8Sync2Reg <= `GPB_RST_ZERO8;
    end else if (ce) begin
      b6Sync1Reg <= bank6PinIn;
      b6Sync2Reg <= b6Sync1Reg;
      b6PrevReg  <= b6Sync2Reg;
      b8Sync1Reg <= bank8PinIn;
      b8Sync2Reg <= b8Sync1Reg;
    end
  end

  // pin events: either edge on 6.0/6.1 in edge mode, rising request on 6.2
  always @* begin
    events = 3'h0;
    if (fn60 == `GPB_FN_EDGE_IRQ) begin
      events[`GPB_EV_EDGE4] = b6Seen[0] ^ b6Prev[0]; // RULE4
    end
    if (fn61 == `GPB_FN_EDGE_IRQ) begin
      events[`GPB_EV_EDGE5] = b6Seen[1] ^ b6Prev[1]; // RULE5
    end
    if (fn62) begin
      events[`GPB_EV_IRQC] = b6Seen[2] & ~b6Prev[2]; // RULE6
    end
  end

  // sticky status: write one clears, a same-cycle event wins over the clear
  always @* begin
    irqStatNext = irqStatReg;
    if (wrDone && hit(paddr, `GPB_IDX_IRQSTAT)) begin
      irqStatNext = irqStatNext & ~pwdata[2:0];
    end
    irqStatNext = irqStatNext | events;
  end

  // bank 8 data: bus write, then selective reset from main power or host bus
  always @* begin
    b8DataNext = b8DataReg;
    if (wrDone && hit(paddr, `GPB_IDX_B8DATA)) begin
      b8DataNext = pwdata[7:0];
    end
    if (mainPowerReset || hostBusReset) begin
      b8DataNext = (b8DataNext & ~b8RstEnReg) | (`GPB_RST_B8DATA & b8RstEnReg); // RULE10
    end
  end

  // software registers; reserved config bits are stored but steer nothing
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin60Reg   <= `GPB_RST_PIN60;
      pin61Reg   <= `GPB_RST_PIN61;
      pin62Reg   <= `GPB_RST_PIN62;
      b8DataReg  <= `GPB_RST_B8DATA; // RULE9
      b8DirReg   <= `GPB_RST_B8DIR; // RULE9
      b8RstEnReg <= `GPB_RST_ZERO8;
      b6DataReg  <= `GPB_RST_ZERO3;
      irqStatReg <= `GPB_RST_ZERO3;
      irqMaskReg <= `GPB_RST_ZERO3;
    end else if (ce) begin
      irqStatReg <= irqStatNext;
      b8DataReg  <= b8DataNext;
      if (wrDone) begin
        if (hit(paddr, `GPB_IDX_PIN60)) begin
          pin60Reg <= pwdata[7:0];
        end
        if (hit(paddr, `GPB_IDX_PIN61)) begin
          pin61Reg <= pwdata[7:0];
        end
        if (hit(paddr, `GPB_IDX_PIN62)) begin
          pin62Reg <= pwdata[7:0];
        end
        if (hit(paddr, `GPB_IDX_B8DIR)) begin
          b8DirReg <= pwdata[7:0];
        end
        if (hit(paddr, `GPB_IDX_B8RSTEN)) begin
          b8RstEnReg <= pwdata[7:0];
        end
        if (hit(paddr, `GPB_IDX_B6DATA)) begin
          b6DataReg <= pwdata[2:0];
        end
        if (hit(paddr, `GPB_IDX_IRQMASK)) begin
          irqMaskReg <= pwdata[2:0];
        end
      end
    end
  end

  // bank 6 routing: the selected function decides direction and source
  always @* begin
    pinIsOut = {~pin62Reg[`GPB_BIT_DIR], ~pin61Reg[`GPB_BIT_DIR], ~pin60Reg[`GPB_BIT_DIR]}; // RULE1
    pinDrv   = b6DataReg ^ polMask; // RULE2
    case (fn60)
      `GPB_FN_GPIO: begin
      end
      `GPB_FN_INDICATOR: begin
        pinIsOut[0] = 1'b1; // RULE11
        pinDrv[0]   = indicatorOutOne ^ polMask[0]; // RULE4
      end
      default: begin
        pinIsOut[0] = 1'b0; // RULE11
      end
    endcase
    case (fn61)
      `GPB_FN_GPIO: begin
      end
      `GPB_FN_INDICATOR: begin
        pinIsOut[1] = 1'b1; // RULE11
        pinDrv[1]   = indicatorOutTwo ^ polMask[1]; // RULE5
      end
      default: begin
        pinIsOut[1] = 1'b0; // RULE11
      end
    endcase
    if (fn62) begin
      pinIsOut[2] = 1'b0; // RULE6
    end
    d0 = drive(pinDrv[0], pin60Reg[`GPB_BIT_ODRAIN]); // RULE3
    d1 = drive(pinDrv[1], pin61Reg[`GPB_BIT_ODRAIN]);
    d2 = drive(pinDrv[2], pin62Reg[`GPB_BIT_ODRAIN]);
  end

  // bank 8 pins: data bit n goes to pin n, always push-pull
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      b8Out[i] = b8DataReg[i]; // RULE8
      b8Oe[i]  = ~b8DirReg[i];
    end
  end

  // read mux; unmapped words read zero and raise pslverr
  always @* begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr, `GPB_IDX_PIN60)) begin
      rdData[7:0] = pin60Reg;
    end else if (hit(paddr, `GPB_IDX_PIN61)) begin
      rdData[7:0] = pin61Reg;
    end else if (hit(paddr, `GPB_IDX_PIN62)) begin
      rdData[7:0] = pin62Reg;
    end else if (hit(paddr, `GPB_IDX_B8DATA)) begin
      rdData[7:0] = (b8DataReg & ~b8DirReg) | (b8Sync2Reg & b8DirReg); // RULE8
    end else if (hit(paddr, `GPB_IDX_IRQSTAT)) begin
      rdData[2:0] = irqStatReg;
    end else if (hit(paddr, `GPB_IDX_IRQMASK)) begin
      rdData[2:0] = irqMaskReg;
    end else if (hit(paddr, `GPB_IDX_B8RSTEN)) begin
      rdData[7:0] = b8RstEnReg;
    end else if (hit(paddr, `GPB_IDX_B8DIR)) begin
      rdData[7:0] = b8DirReg;
    end else if (hit(paddr, `GPB_IDX_PINSTAT)) begin
      rdData[2:0] = b6Seen;
    end else if (hit(paddr, `GPB_IDX_B6DATA)) begin
      rdData[2:0] = b6DataReg;
    end else begin
      mapped = 1'b0;
    end
  end

  // apb answer: one wait-free access phase, prepared during setup
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      if (setup) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= pwrite ? 32'h0000_0000 : rdData;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // registered pin drive and interrupt outputs
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bank6PinOut      <= 3'h0;
      bank6PinOe       <= 3'h0; // bank 6 enables clear in reset; pin 6.1 resets to indicator two and drives once reset ends
      bank8PinOut      <= `GPB_RST_B8DATA;
      bank8PinOe       <= ~`GPB_RST_B8DIR; // RULE9
      irqRequestInputC <= 1'b0;
      irqOut           <= 1'b0;
    end else if (ce) begin
      bank6PinOut      <= {d2[1], d1[1], d0[1]};
      bank6PinOe       <= {d2[0], d1[0], d0[0]} & pinIsOut; // RULE11
      bank8PinOut      <= b8Out;
      bank8PinOe       <= b8Oe;
      irqRequestInputC <= fn62 & b6Seen[2]; // RULE6
      irqOut           <= |(irqStatNext & irqMaskReg);
    end
  end

endmodule

// ### test/gpb_bank_config_assertions.sv
module gpb_bank_config_checker (
  input logic        mclk,
  input logic        rstn,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        indicatorOutOne,
  input logic        indicatorOutTwo,
  input logic        irqRequestInputC,
  input logic [2:0]  bank6PinOut,
  input logic [2:0]  bank6PinOe,
  input logic [7:0]  bank8PinOut,
  input logic [7:0]  bank8PinOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cfg0_reg, cfg1_reg, cfg2_reg;
  wire wrEn = ce && psel && penable && pready && pwrite;
  // shadow of the pin configs, written at the same edge as the design's copy
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) {cfg0_reg, cfg1_reg, cfg2_reg} <= 24'h010401;
    else if (wrEn) begin
      if (paddr == 12'h11c) cfg0_reg <= pwdata[7:0];
      if (paddr == 12'h120) cfg1_reg <= pwdata[7:0];
      if (paddr == 12'h124) cfg2_reg <= pwdata[7:0];
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // $stable waits out the one edge the outputs lag a config write
  a_setup_ready: assert property (ce && psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  a_b8_reset: assert property ($rose(rstn) |-> bank8PinOut == 8'hf0 && bank8PinOe == 8'hff)
    else $error("bank 8 pins not at reset state");
  a_b8_map: assert property (wrEn && paddr == 12'h128 |-> ##2 bank8PinOut == $past(pwdata[7:0], 2))
    else $error("bank 8 pins differ from data written");
  a_dir_gpio: assert property ($stable(cfg2_reg) && !cfg2_reg[2] && !cfg2_reg[7] |-> bank6PinOe[2] == !cfg2_reg[0])
    else $error("pin 6.2 enable disagrees with direction");
  a_open_drain: assert property ($stable(cfg2_reg) && cfg2_reg[7] && !cfg2_reg[2] |-> !bank6PinOut[2])
    else $error("open drain pin drives high");
  a_ind_one: assert property ($past(rstn) && $stable(cfg0_reg) && cfg0_reg[3:2] == 2'h1
    && !cfg0_reg[7] |-> bank6PinOe[0] && bank6PinOut[0] == ($past(indicatorOutOne) ^ cfg0_reg[1]))
    else $error("indicator one not on pin 6.0");
  a_ind_two: assert property ($past(rstn) && $stable(cfg1_reg) && cfg1_reg[3:2] == 2'h1
    && !cfg1_reg[7] |-> bank6PinOe[1] && bank6PinOut[1] == ($past(indicatorOutTwo) ^ cfg1_reg[1]))
    else $error("indicator two not on pin 6.1");
  a_edge_input: assert property ($stable(cfg0_reg) && cfg0_reg[3:2] == 2'h2 |-> !bank6PinOe[0])
    else $error("edge input pin is driven");
  a_irqc_off: assert property ($stable(cfg2_reg) && !cfg2_reg[2] |-> !irqRequestInputC)
    else $error("request input active in gpio mode");
endmodule

bind gpb_bank_config gpb_bank_config_checker chk (.mclk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .indicatorOutOne, .indicatorOutTwo, .irqRequestInputC, .bank6PinOut, .bank6PinOe, .bank8PinOut,
  .bank8PinOe);

// ### test/gpb_board_model.sv
module gpb_board_model (
  input  logic [2:0] b6Out,
  input  logic [2:0] b6Oe,
  input  logic [2:0] extLevel,
  input  logic [2:0] extOe,
  input  logic [7:0] b8Out,
  input  logic [7:0] b8Oe,
  output logic [2:0] b6Wire,
  output logic [7:0] b8Wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // board pull-ups: a released line reads high, which open drain relies on
  assign b6Wire = (b6Oe & b6Out) | (~b6Oe & ((extOe & extLevel) | ~extOe));
  assign b8Wire = (b8Oe & b8Out) | ~b8Oe;
endmodule

// ### test/tb_gpio_bank6_bank8_config.sv
module tb_gpio_bank6_bank8_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, mainPowerReset = 0, ind1 = 0, ind2 = 0, err;
  logic ce = 1, hostBusReset = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic pready, pslverr, irqC, irqOut;
  logic [2:0] b6Out, b6Oe, b6Wire, extLevel = 0, extOe = 0;
  logic [7:0] b8Out, b8Oe, b8Wire;
  int failures = 0, comparisons = 0, cycles = 0;
  int mdl[int];
  always #2.5 mclk = ~mclk;
  gpb_bank_config DUT (.mclk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mainPowerReset, .hostBusReset, .indicatorOutOne(ind1), .indicatorOutTwo(ind2),
    .irqRequestInputC(irqC), .irqOut, .bank6PinIn(b6Wire), .bank6PinOut(b6Out), .bank6PinOe(b6Oe),
    .bank8PinIn(b8Wire), .bank8PinOut(b8Out), .bank8PinOe(b8Oe));
  gpb_board_model board (.b6Out, .b6Oe, .extLevel, .extOe, .b8Out, .b8Oe, .b6Wire, .b8Wire);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the model mirrors config writes
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (wr && mdl.exists(a)) mdl[a] = d[7:0];
  endtask
  task automatic rc(input logic [11:0] a);
    apb(0, a, 0);
    check(rd, mdl[a]);
  endtask
  // model contents right after a standby reset
  task automatic reset_model;
    mdl[12'h11c] = 8'h01;
    mdl[12'h120] = 8'h04;
    mdl[12'h124] = 8'h01;
    mdl[12'h128] = 8'hf0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    v = $urandom(79122);
    reset_model();
    repeat (20) @(posedge mclk);
    rstn <= 1;
    foreach (mdl[a]) rc(a);
    apb(0, 12'h000, 0);
    check({rd[30:0], err}, 32'h1);
    $display("done: reset values");
    repeat (4) begin
      v = $urandom;
      apb(1, 12'h128, v);
      settle(1);
      check(b8Out, v[7:0]);
      rc(12'h128);
    end
    $display("done: bank 8 data");
    extOe <= 3'h4;
    for (int p = 0; p < 2; p++) begin
      apb(1, 12'h124, {p[0], 1'b1});
      v = $urandom;
      extLevel <= {v[0], 2'b00};
      settle(5);
      apb(0, 12'h190, 0);
      check({b6Oe[2], rd[2]}, v[0] ^ p[0]);
    end
    extOe <= 0;
    apb(1, 12'h194, 32'h4);
    apb(1, 12'h124, 8'h00);
    settle(2);
    check({b6Oe[2], b6Out[2]}, 2'b11);
    apb(1, 12'h124, 8'h80);
    settle(2);
    check({b6Oe[2], b6Out[2], b6Wire[2]}, 3'b001);
    $display("done: direction and driver");
    apb(1, 12'h11c, 8'h04);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {ind1, ind2} <= i[1:0];
      settle(2);
      check({b6Oe[1:0], b6Out[1:0]}, {2'b11, i[0], i[1]});
    end
    $display("done: indicators");
    // software keeps function codes within 00..10
    apb(1, 12'h11c, 8'h09);
    apb(1, 12'h184, 1);
    extOe <= 3'h5;
    extLevel <= 0;
    settle(5);
    apb(1, 12'h180, 7);
    extLevel <= 3'h1;
    settle(5);
    apb(0, 12'h180, 0);
    check({irqOut, rd[2:0]}, 4'h9);
    apb(1, 12'h180, 1);
    apb(1, 12'h184, 0);
    extLevel <= 0;
    settle(5);
    apb(0, 12'h180, 0);
    check({irqOut, rd[2:0]}, 4'h1);
    $display("done: edge interrupt");
    apb(1, 12'h124, 8'h05);
    for (int l = 1; l >= 0; l--) begin
      @(posedge mclk);
      extLevel <= {l[0], 2'b00};
      settle(5);
      check(irqC, l[0]);
    end
    // the rise on 6.2 joins the edge four bit still pending; mask is off
    apb(0, 12'h180, 0);
    check({irqOut, rd[2:0]}, 4'h5);
    $display("done: request input");
    apb(1, 12'h188, 8'h10);
    apb(1, 12'h128, 0);
    repeat (2) @(posedge mclk);
    mainPowerReset <= 1;
    repeat (2) @(posedge mclk);
    mainPowerReset <= 0;
    mdl[12'h128] = 8'h10;
    foreach (mdl[a]) rc(a);
    // a frozen block ignores the reload; let the pins follow the write first
    apb(1, 12'h188, 8'h0f);
    apb(1, 12'h128, 8'h5a);
    repeat (2) @(posedge mclk);
    ce <= 0;
    mainPowerReset <= 1;
    repeat (3) @(posedge mclk);
    ce <= 1;
    mainPowerReset <= 0;
    rc(12'h128);
    hostBusReset <= 1;
    repeat (2) @(posedge mclk);
    hostBusReset <= 0;
    mdl[12'h128] = 8'h50; // reset value lands on enabled bits 3..0 only
    rc(12'h128);
    // input bits read the pulled-up pins instead of the stored data
    apb(1, 12'h18c, 8'h0f);
    settle(3);
    check(b8Oe, 8'hf0);
    apb(0, 12'h128, 0);
    check(rd, 8'h5f);
    $display("done: partial reset");
    rstn <= 0;
    repeat (3) @(posedge mclk);
    rstn <= 1;
    reset_model();
    settle(1);
    check({b8Oe, b8Out}, 16'hfff0);
    foreach (mdl[a]) rc(a);
    $display("done: second reset");
    print_verdict();
  end
endmodule
